// file: src/serial_port_pkg.sv
// constants, field layout and carrier types of the four-mode serial port
// assumes one oscillator clock shared with the cpu core and timer 1
package serial_port_pkg;

	// special function register addresses
	localparam logic [7:0] CTRL_ADDR = 8'h98;
	localparam logic [7:0] BUF_ADDR  = 8'h99;

	// control register bit positions, msb to lsb
	localparam int MODE_HI_BIT = 7;
	localparam int MODE_LO_BIT = 6;
	localparam int MPF_BIT     = 5;
	localparam int REN_BIT     = 4;
	localparam int TB8_BIT     = 3;
	localparam int RB8_BIT     = 2;
	localparam int TI_BIT      = 1;
	localparam int RI_BIT      = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] BUF_RESET  = 8'h00;

	// mode select encodings
	localparam logic [1:0] MODE0 = 2'h0;
	localparam logic [1:0] MODE1 = 2'h1;
	localparam logic [1:0] MODE2 = 2'h2;
	localparam logic [1:0] MODE3 = 2'h3;

	// mode 0: one shift clock per twelve oscillator clocks
	localparam int         M0_DIV    = 12;
	localparam logic [3:0] M0_LAST   = 4'(M0_DIV - 1);
	localparam logic [3:0] M0_RISE   = 4'(M0_DIV / 2 - 1);
	localparam logic [3:0] M0_BITS   = 4'h8;

	// uart modes: sixteen sample ticks per bit
	localparam int         OVERSAMPLE = 16;
	localparam logic [3:0] BIT_LAST   = 4'(OVERSAMPLE - 1);
	localparam logic [3:0] SAMPLE_PT  = 4'(OVERSAMPLE / 2 - 1);
	localparam int         M2_DIV_SLOW = 64;
	localparam int         M2_DIV_FAST = 32;
	localparam int         T1_DIV_SLOW = 32;
	localparam int         T1_DIV_FAST = 16;
	localparam logic [1:0] M2_LIM_SLOW = 2'(M2_DIV_SLOW / OVERSAMPLE - 1);
	localparam logic [1:0] M2_LIM_FAST = 2'(M2_DIV_FAST / OVERSAMPLE - 1);
	localparam logic [1:0] T1_LIM_SLOW = 2'(T1_DIV_SLOW / OVERSAMPLE - 1);
	localparam logic [1:0] T1_LIM_FAST = 2'(T1_DIV_FAST / OVERSAMPLE - 1);

	// frame lengths in bit times
	localparam logic [3:0] UART8_BITS = 4'ha;
	localparam logic [3:0] UART9_BITS = 4'hb;

	// special function register access from the core
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} sfr_req_s;

endpackage

// file: src/four_mode_serial_port.sv
// four-mode serial port: shift register, 8-bit and 9-bit uart
// assumes sfr strobes and timer 1 overflow on sys_clk; rxd from a pin
`timescale 1ns/1ns

module four_mode_serial_port
	import serial_port_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire sfr_req_s   sfr_req,
	output logic      [7:0] sfr_rdata,
	input  wire logic       baud_doubler,
	input  wire logic       timer1_overflow,
	input  wire logic       rxd_in,
	output logic            rxd_out,
	output logic            rxd_oe,
	output logic            txd,
	output logic            serial_irq
);

	typedef enum {TX_IDLE, TX_SEND} tx_st_e;
	typedef enum {RX_IDLE, RX_START, RX_DATA} rx_st_e;
	typedef enum {M0_IDLE, M0_SEND, M0_RECV} m0_st_e;

	function automatic logic hit(input sfr_req_s r, input logic [7:0] a);
		hit = (r.addr == a);
	endfunction

	logic        rxd_s1;
	logic        rxd_s2;
	logic [1:0]  mode_r;
	logic        mpf_r;
	logic        ren_r;
	logic        tb8_r;
	logic        rb8_r;
	logic        ti_r;
	logic        ri_r;
	logic [7:0]  rbuf_r;
	logic [7:0]  rdata_r;
	logic        irq_r;
	logic        txd_r;
	logic        ctrl_wr;
	logic        buf_wr;
	logic [1:0]  samp_cnt_r;
	logic        samp_tick_r;
	logic        samp_ev;
	logic [1:0]  samp_lim;
	tx_st_e      tx_st_r;
	logic [10:0] tx_sh_r;
	logic [3:0]  tx_left_r;
	logic [3:0]  tx_div_r;
	logic        utx_line_r;
	logic        utx_done_r;
	rx_st_e      rx_st_r;
	logic [9:0]  rx_sh_r;
	logic [9:0]  rx_next;
	logic [3:0]  rx_left_r;
	logic [3:0]  rx_cnt_r;
	logic [7:0]  rx_byte;
	logic        rx_b9;
	logic        urx_load_r;
	logic [7:0]  urx_byte_r;
	logic        urx_b9_r;
	m0_st_e      m0_st_r;
	logic [7:0]  m0_sh_r;
	logic [3:0]  m0_div_r;
	logic [3:0]  m0_left_r;
	logic        m0_clk_r;
	logic        m0_out_r;
	logic        m0_oe_r;
	logic        m0_ti_r;
	logic        m0_ri_r;

	assign ctrl_wr    = sfr_req.wr && hit(sfr_req, CTRL_ADDR);
	assign buf_wr     = sfr_req.wr && hit(sfr_req, BUF_ADDR);
	assign sfr_rdata  = rdata_r;
	assign serial_irq = irq_r;
	assign txd        = txd_r;
	assign rxd_out    = m0_out_r;
	assign rxd_oe     = m0_oe_r;

	////////////////////////////////////////////////////////////////////
	// pin synchroniser

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxd_s1 <= 1'b1;
			rxd_s2 <= 1'b1;
		end else begin
			rxd_s1 <= rxd_in;
			rxd_s2 <= rxd_s1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// control register and flags

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_r <= CTRL_RESET[MODE_HI_BIT:MODE_LO_BIT];
			mpf_r  <= CTRL_RESET[MPF_BIT];
			ren_r  <= CTRL_RESET[REN_BIT];
			tb8_r  <= CTRL_RESET[TB8_BIT];
		end else if (ctrl_wr) begin
			mode_r <= sfr_req.wdata[MODE_HI_BIT:MODE_LO_BIT];
			mpf_r  <= sfr_req.wdata[MPF_BIT];
			ren_r  <= sfr_req.wdata[REN_BIT];
			tb8_r  <= sfr_req.wdata[TB8_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ti_r  <= CTRL_RESET[TI_BIT];
			ri_r  <= CTRL_RESET[RI_BIT];
			rb8_r <= CTRL_RESET[RB8_BIT];
		end else begin
			// hardware set wins over a software write
			ti_r <= utx_done_r | m0_ti_r |
				(ctrl_wr ? sfr_req.wdata[TI_BIT] : ti_r);
			ri_r <= urx_load_r | m0_ri_r |
				(ctrl_wr ? sfr_req.wdata[RI_BIT] : ri_r);
			if (urx_load_r)
				rb8_r <= urx_b9_r;
			else if (ctrl_wr)
				rb8_r <= sfr_req.wdata[RB8_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			rbuf_r <= BUF_RESET;
		else if (urx_load_r)
			rbuf_r <= urx_byte_r;
		else if (m0_ri_r)
			rbuf_r <= m0_sh_r;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_r <= 8'h00;
			irq_r   <= 1'b0;
		end else begin
			irq_r <= ti_r | ri_r;
			if (sfr_req.rd && hit(sfr_req, CTRL_ADDR))
				rdata_r <= {mode_r, mpf_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};
			else if (sfr_req.rd && hit(sfr_req, BUF_ADDR))
				rdata_r <= rbuf_r;
			else
				rdata_r <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////
	// sample tick, sixteen per bit in uart modes

	always_comb begin
		if (mode_r == MODE2) begin
			samp_ev  = 1'b1;
			samp_lim = baud_doubler ? M2_LIM_FAST : M2_LIM_SLOW;
		end else begin
			samp_ev  = timer1_overflow;
			samp_lim = baud_doubler ? T1_LIM_FAST : T1_LIM_SLOW;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			samp_cnt_r  <= 2'h0;
			samp_tick_r <= 1'b0;
		end else begin
			samp_tick_r <= 1'b0;
			if (mode_r == MODE0) begin
				samp_cnt_r <= 2'h0;
			end else if (samp_ev) begin
				if (samp_cnt_r >= samp_lim) begin
					samp_cnt_r  <= 2'h0;
					samp_tick_r <= 1'b1;
				end else begin
					samp_cnt_r <= samp_cnt_r + 2'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// uart transmitter, independent of the receiver

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_st_r    <= TX_IDLE;
			tx_sh_r    <= 11'h7ff;
			tx_left_r  <= 4'h0;
			tx_div_r   <= 4'h0;
			utx_line_r <= 1'b1;
			utx_done_r <= 1'b0;
		end else begin
			utx_done_r <= 1'b0;
			if (buf_wr && mode_r != MODE0) begin
				tx_st_r   <= TX_SEND;
				// stop, ninth (or stop), data lsb first, start
				tx_sh_r   <= {1'b1, (mode_r == MODE1) ? 1'b1 : tb8_r,
					sfr_req.wdata, 1'b0};
				tx_left_r <= (mode_r == MODE1) ? UART8_BITS : UART9_BITS;
				tx_div_r  <= 4'h0;
				utx_line_r <= 1'b0;
			end else begin
				case (tx_st_r)
				TX_IDLE: begin
					utx_line_r <= 1'b1;
				end
				TX_SEND: begin
					if (samp_tick_r) begin
						tx_div_r <= tx_div_r + 4'h1;
						if (tx_div_r == BIT_LAST) begin
							if (tx_left_r == 4'h1) begin
								tx_st_r    <= TX_IDLE;
								utx_done_r <= 1'b1;
								utx_line_r <= 1'b1;
							end else begin
								tx_sh_r    <= {1'b1, tx_sh_r[10:1]};
								utx_line_r <= tx_sh_r[1];
								tx_left_r  <= tx_left_r - 4'h1;
							end
						end
					end
				end
				default: tx_st_r <= TX_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// uart receiver

	always_comb begin
		rx_next = {rxd_s2, rx_sh_r[9:1]};
		if (mode_r == MODE1) begin
			rx_byte = rx_next[8:1];
			rx_b9   = rx_next[9];
		end else begin
			rx_byte = rx_next[7:0];
			rx_b9   = rx_next[8];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_st_r    <= RX_IDLE;
			rx_sh_r    <= 10'h000;
			rx_left_r  <= 4'h0;
			rx_cnt_r   <= 4'h0;
			urx_load_r <= 1'b0;
			urx_byte_r <= 8'h00;
			urx_b9_r   <= 1'b0;
		end else begin
			urx_load_r <= 1'b0;
			if (mode_r == MODE0 || !ren_r) begin
				rx_st_r <= RX_IDLE;
			end else if (samp_tick_r) begin
				case (rx_st_r)
				RX_IDLE: begin
					if (!rxd_s2) begin
						rx_st_r  <= RX_START;
						rx_cnt_r <= 4'h0;
					end
				end
				RX_START: begin
					rx_cnt_r <= rx_cnt_r + 4'h1;
					if (rx_cnt_r == SAMPLE_PT && rxd_s2)
						rx_st_r <= RX_IDLE;
					else if (rx_cnt_r == BIT_LAST) begin
						rx_st_r   <= RX_DATA;
						rx_left_r <= (mode_r == MODE1) ?
							UART8_BITS - 4'h1 : UART9_BITS - 4'h1;
					end
				end
				RX_DATA: begin
					rx_cnt_r <= rx_cnt_r + 4'h1;
					if (rx_cnt_r == SAMPLE_PT) begin
						rx_sh_r   <= rx_next;
						rx_left_r <= rx_left_r - 4'h1;
						if (rx_left_r == 4'h1) begin
							rx_st_r <= RX_IDLE;
							// unread byte keeps priority
							if (!ri_r && (!mpf_r || rx_b9)) begin
								urx_load_r <= 1'b1;
								urx_byte_r <= rx_byte;
								urx_b9_r   <= rx_b9;
							end
						end
					end
				end
				default: rx_st_r <= RX_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// mode 0 shift register, filter bit unused here

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			m0_st_r   <= M0_IDLE;
			m0_sh_r   <= 8'h00;
			m0_div_r  <= 4'h0;
			m0_left_r <= 4'h0;
			m0_clk_r  <= 1'b1;
			m0_out_r  <= 1'b1;
			m0_oe_r   <= 1'b0;
			m0_ti_r   <= 1'b0;
			m0_ri_r   <= 1'b0;
		end else begin
			m0_ti_r <= 1'b0;
			m0_ri_r <= 1'b0;
			if (mode_r != MODE0) begin
				m0_st_r  <= M0_IDLE;
				m0_clk_r <= 1'b1;
				m0_oe_r  <= 1'b0;
			end else if (buf_wr) begin
				m0_st_r   <= M0_SEND;
				m0_sh_r   <= sfr_req.wdata;
				m0_out_r  <= sfr_req.wdata[0];
				m0_oe_r   <= 1'b1;
				m0_div_r  <= 4'h0;
				m0_left_r <= M0_BITS;
				m0_clk_r  <= 1'b0;
			end else begin
				case (m0_st_r)
				M0_IDLE: begin
					m0_clk_r <= 1'b1;
					m0_oe_r  <= 1'b0;
					if (ren_r && !ri_r && !m0_ri_r) begin
						m0_st_r   <= M0_RECV;
						m0_div_r  <= 4'h0;
						m0_left_r <= M0_BITS;
						m0_clk_r  <= 1'b0;
					end
				end
				M0_SEND, M0_RECV: begin
					// clock low for six, high for six
					m0_div_r <= (m0_div_r == M0_LAST) ?
						4'h0 : m0_div_r + 4'h1;
					m0_clk_r <= (m0_div_r >= M0_RISE) &&
						(m0_div_r != M0_LAST);
					if (m0_div_r == M0_LAST) begin
						m0_left_r <= m0_left_r - 4'h1;
						if (m0_st_r == M0_RECV)
							m0_sh_r <= {rxd_s2, m0_sh_r[7:1]};
						else begin
							m0_sh_r  <= {1'b0, m0_sh_r[7:1]};
							m0_out_r <= m0_sh_r[1];
						end
						if (m0_left_r == 4'h1) begin
							m0_st_r <= M0_IDLE;
							m0_oe_r <= 1'b0;
							m0_clk_r <= 1'b1;
							if (m0_st_r == M0_SEND)
								m0_ti_r <= 1'b1;
							else
								m0_ri_r <= 1'b1;
						end
					end
				end
				default: m0_st_r <= M0_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// transmit pin: shift clock in mode 0, serial line otherwise

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			txd_r <= 1'b1;
		else
			txd_r <= (mode_r == MODE0) ? m0_clk_r : utx_line_r;
	end

endmodule

// file: verif/serial_port_props.sv
// checker bound to the serial port's ports
// assumes timer 1 ticks give uart bits of 32 clocks or more
`timescale 1ns/1ns

module serial_port_props
	import serial_port_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       rst_b,
	input wire sfr_req_s   sfr_req,
	input wire logic [7:0] sfr_rdata,
	input wire logic       baud_doubler,
	input wire logic       timer1_overflow,
	input wire logic       rxd_in,
	input wire logic       rxd_out,
	input wire logic       rxd_oe,
	input wire logic       txd,
	input wire logic       serial_irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	logic [1:0] mode_r;
	logic [7:0] oe_cnt_r;
	logic [7:0] hold_r;
	logic       c_wr;
	logic       b_wr;
	logic       c_rd;

	assign c_wr = sfr_req.wr && sfr_req.addr == CTRL_ADDR;
	assign b_wr = sfr_req.wr && sfr_req.addr == BUF_ADDR;
	assign c_rd = sfr_req.rd && sfr_req.addr == CTRL_ADDR;

	////////////////////////////////////////////////////////////////////
	// mode shadow, drive length, cycles since txd moved
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			mode_r <= MODE0;
		else if (c_wr)
			mode_r <= sfr_req.wdata[MODE_HI_BIT:MODE_LO_BIT];
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			oe_cnt_r <= 8'h00;
		else
			oe_cnt_r <= rxd_oe ? oe_cnt_r + 8'h01 : 8'h00;
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			hold_r <= 8'hff;
		else if ($changed(txd))
			hold_r <= 8'h00;
		else if (hold_r != 8'hff)
			hold_r <= hold_r + 8'h01;
	end

	////////////////////////////////////////////////////////////////////
	a_rdata_idle: assert property (
		!sfr_req.rd |=> sfr_rdata == 8'h00)
		else $error("read data not idle");
	a_ctrl_readback: assert property (
		c_wr ##2 c_rd |=> sfr_rdata[7:3] == $past(sfr_req.wdata[7:3], 3))
		else $error("control bits lost");
	a_irq_flags: assert property (
		c_rd ##1 sfr_rdata[1:0] != 2'h0 |-> ##[0:2] serial_irq)
		else $error("flag without interrupt");
	a_tx_start: assert property (
		b_wr && mode_r != MODE0 |-> ##[1:3] !txd)
		else $error("no start bit");
	a_m0_first: assert property (
		b_wr && mode_r == MODE0 |=>
		rxd_oe && rxd_out == $past(sfr_req.wdata[0]))
		else $error("mode 0 first bit wrong");
	a_m0_len: assert property (
		$fell(rxd_oe) |-> oe_cnt_r == 8'h60)
		else $error("mode 0 send length");
	a_m0_clock: assert property (
		rxd_oe && $fell(txd) |-> !txd [*6] ##1 txd [*6])
		else $error("shift clock phase");
	a_m0_hold: assert property (
		rxd_oe && $rose(txd) |-> $stable(rxd_out) [*5])
		else $error("data moved in high phase");
	a_uart_bit: assert property (
		mode_r != MODE0 && $changed(txd) |-> hold_r >= 8'h1e)
		else $error("uart bit too short");
endmodule

// file: verif/serial_node.sv
// far-side serial node: drives the rxd line, watches txd
// assumes the bench calls one frame task at a time per direction
`timescale 1ns/1ns

module serial_node (
	input  wire logic sys_clk,
	input  wire logic txd,
	input  wire logic rxd_oe,
	input  wire logic rxd_out,
	output logic      rxd_in
);
	logic drv = 1'b1;

	// rxd wire: port drive wins, else node, released pulled up
	assign rxd_in = rxd_oe ? rxd_out : drv;

	////////////////////////////////////////////////////////////////////
	// uart frame out, lsb first, bl clocks per bit
	task automatic send(input logic [10:0] f, input int n, input int bl);
		for (int i = 0; i < n; i++) begin
			drv = f[i];
			repeat (bl) @(negedge sys_clk);
		end
		drv = 1'b1;
	endtask
	// uart frame in, sampled mid bit
	task automatic grab(input int n, input int bl, output logic [10:0] f);
		f = 11'h000;
		@(negedge txd);
		repeat (bl / 2) @(negedge sys_clk);
		for (int i = 0; i < n; i++) begin
			f[i] = txd;
			repeat (bl) @(negedge sys_clk);
		end
	endtask
	// mode 0: new bit at each falling shift clock
	task automatic m0_feed(input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			@(negedge txd);
			@(negedge sys_clk);
			drv = d[i];
		end
		@(posedge txd);
		repeat (8) @(negedge sys_clk);
		drv = 1'b1;
	endtask
	task automatic m0_grab(output logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			@(posedge txd);
			d[i] = rxd_in;
		end
	endtask
endmodule

// file: verif/test_four_mode_serial_port.sv
// testbench for the four-mode serial port with a far-side node
// assumes the node model and the checker are compiled first
`timescale 1ns/1ns

module test_four_mode_serial_port;
	import serial_port_pkg::*;

	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	sfr_req_s    sfr_req = '0;
	logic [7:0]  sfr_rdata;
	logic        baud_doubler = 1'b0;
	logic        timer1_overflow = 1'b0;
	logic        rxd_in;
	logic        rxd_out;
	logic        rxd_oe;
	logic        txd;
	logic        serial_irq;
	int          num_errors = 0;
	int          n_tests = 0;
	int          cycles = 0;
	logic [10:0] got;
	logic [7:0]  rd8;

	four_mode_serial_port uut (.sys_clk, .rst_b, .sfr_req, .sfr_rdata,
		.baud_doubler, .timer1_overflow, .rxd_in, .rxd_out, .rxd_oe, .txd,
		.serial_irq);
	serial_node node (.sys_clk, .txd, .rxd_oe, .rxd_out, .rxd_in);

	always #5 sys_clk = ~sys_clk;
	always @(negedge sys_clk) timer1_overflow <= ~timer1_overflow;

	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [10:0] seen, input logic [10:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		sfr_req.addr = a;
		sfr_req.wdata = d;
		sfr_req.wr = 1'b1;
		@(negedge sys_clk);
		sfr_req.wr = 1'b0;
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
		@(negedge sys_clk);
		sfr_req.addr = a;
		sfr_req.rd = 1'b1;
		@(negedge sys_clk);
		check({3'h0, sfr_rdata}, {3'h0, e});
		sfr_req.rd = 1'b0;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		chk_reg(CTRL_ADDR, CTRL_RESET);
		chk_reg(BUF_ADDR, BUF_RESET);
		wr_reg(8'h97, 8'hff);
		chk_reg(8'h97, 8'h00);
		wr_reg(CTRL_ADDR, {MODE3, 6'h38});
		chk_reg(CTRL_ADDR, {MODE3, 6'h38});
		$display("test registers done");
	endtask
	task automatic t_m2_tx;
		for (int db = 0; db < 2; db++) begin
			baud_doubler = db[0];
			wr_reg(CTRL_ADDR, {MODE2, 2'h0, db[0], 3'h0});
			fork
				node.grab(11, db ? 32 : 64, got);
				wr_reg(BUF_ADDR, 8'h5a);
			join
			check(got, {1'b1, db[0], 8'h5a, 1'b0});
			chk_reg(CTRL_ADDR, {MODE2, 2'h0, db[0], 3'h2});
			check({10'h000, serial_irq}, 11'h001);
			wr_reg(CTRL_ADDR, 8'h00);
		end
		$display("test mode 2 transmit done");
	endtask
	task automatic t_m1;
		wr_reg(CTRL_ADDR, {MODE1, 6'h10});
		fork
			node.send({2'h3, 8'h3c, 1'b0}, 10, 32);
			node.grab(10, 32, got);
			wr_reg(BUF_ADDR, 8'hc3);
		join
		check(got, {2'h1, 8'hc3, 1'b0});
		chk_reg(CTRL_ADDR, {MODE1, 6'h17});
		chk_reg(BUF_ADDR, 8'h3c);
		node.send({2'h3, 8'h99, 1'b0}, 10, 32);
		chk_reg(BUF_ADDR, 8'h3c);
		wr_reg(CTRL_ADDR, {MODE1, 6'h30});
		node.send({2'h2, 8'h11, 1'b0}, 10, 32);
		chk_reg(CTRL_ADDR, {MODE1, 6'h30});
		node.send({2'h3, 8'h22, 1'b0}, 10, 32);
		chk_reg(BUF_ADDR, 8'h22);
		baud_doubler = 1'b0;
		wr_reg(CTRL_ADDR, {MODE1, 6'h10});
		node.send({2'h3, 8'h5e, 1'b0}, 10, 64);
		chk_reg(BUF_ADDR, 8'h5e);
		chk_reg(CTRL_ADDR, {MODE1, 6'h15});
		baud_doubler = 1'b1;
		$display("test mode 1 duplex done");
	endtask
	task automatic t_m3;
		wr_reg(CTRL_ADDR, {MODE3, 6'h30});
		node.send({2'h2, 8'h44, 1'b0}, 11, 32);
		chk_reg(CTRL_ADDR, {MODE3, 6'h30});
		node.send({2'h3, 8'h81, 1'b0}, 11, 32);
		chk_reg(CTRL_ADDR, {MODE3, 6'h35});
		chk_reg(BUF_ADDR, 8'h81);
		wr_reg(CTRL_ADDR, {MODE3, 6'h10});
		node.send({2'h0, 8'h18, 1'b0}, 11, 32);
		chk_reg(CTRL_ADDR, {MODE3, 6'h11});
		$display("test mode 3 filter done");
	endtask
	task automatic t_m0;
		wr_reg(CTRL_ADDR, 8'h00);
		fork
			node.m0_grab(rd8);
			wr_reg(BUF_ADDR, 8'h96);
		join
		check({3'h0, rd8}, 11'h096);
		repeat (12) @(negedge sys_clk);
		chk_reg(CTRL_ADDR, {MODE0, 6'h02});
		fork
			node.m0_feed(8'h6b);
			wr_reg(CTRL_ADDR, {MODE0, 6'h30});
		join
		repeat (12) @(negedge sys_clk);
		chk_reg(CTRL_ADDR, {MODE0, 6'h31});
		chk_reg(BUF_ADDR, 8'h6b);
		$display("test mode 0 done");
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(negedge sys_clk);
		rst_b = 1'b1;
		t_regs();
		t_m2_tx();
		t_m1();
		t_m3();
		t_m0();
		stop_test();
	end
	always @(negedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			stop_test();
		end
	end
endmodule

bind four_mode_serial_port serial_port_props chk (.sys_clk, .rst_b,
	.sfr_req, .sfr_rdata, .baud_doubler, .timer1_overflow, .rxd_in,
	.rxd_out, .rxd_oe, .txd, .serial_irq);
